// >>> bfc_pkg.sv
// Purpose: shared constants and types of the billboard failover control
// Assumes: 200 MHz clock, APB register access with one word per register
// Notes:   register byte address is four times the register index
`default_nettype none
package bfc_pkg;
  // clock and timing
  localparam int CLK_KHZ        = 200000;
  localparam int TICK_MS        = 10;
  localparam int TICK_CYCLES    = TICK_MS * CLK_KHZ;
  localparam int DETACH_MS      = 100;
  localparam int DETACH_TICKS   = (DETACH_MS + TICK_MS - 1) / TICK_MS;

  // register indices, byte address is index times four
  localparam int ADDR_W         = 18;
  localparam logic [15:0] IDX_TMRA_LO = 16'h413C;
  localparam logic [15:0] IDX_TMRA_HI = 16'h413D;
  localparam logic [15:0] IDX_TMRB_LO = 16'h413E;
  localparam logic [15:0] IDX_TMRB_HI = 16'h413F;
  localparam logic [15:0] IDX_CTRL    = 16'h4140;
  localparam logic [15:0] IDX_STATUS  = 16'h4141;

  // reset values
  localparam logic [7:0] TMRA_LO_RST  = 8'hD0;
  localparam logic [7:0] TMRA_HI_RST  = 8'h07;
  localparam logic [7:0] TMRB_LO_RST  = 8'hD0;
  localparam logic [7:0] TMRB_HI_RST  = 8'h07;
  localparam logic [7:0] CTRL_RST     = 8'h14;

  // control fields
  localparam int         CTRL_EN_BIT  = 0;
  localparam int         CTRL_SEL_LSB = 1;
  localparam int         CTRL_SEL_W   = 5;
  localparam logic [7:0] CTRL_MASK    = 8'h3F;
  localparam logic [4:0] SEL_RESERVED = 5'h09;
  localparam int         DEFAULT_NOTIFY_PIN = 10;

  // status fields
  localparam int ST_RUNA_BIT = 2;
  localparam int ST_RUNB_BIT = 3;
  localparam int ST_ARM_BIT  = 4;
  localparam int ST_FAIL_BIT = 5;
  localparam int ST_CONN_BIT = 6;
  localparam int ST_BB_BIT   = 7;

  // descriptor constants
  localparam logic [1:0]  BM_CONFIG_UNSPEC = 2'h0;
  localparam logic [15:0] BB_CLASS_VERSION = 16'h0110;

  // register select codes
  typedef enum logic [2:0] {
    RS_NONE   = 3'h0,
    RS_TMRA_LO = 3'h1,
    RS_TMRA_HI = 3'h2,
    RS_TMRB_LO = 3'h3,
    RS_TMRB_HI = 3'h4,
    RS_CTRL    = 3'h5,
    RS_STATUS  = 3'h6
  } bfc_regsel_t;

  // connection states, gray order
  typedef enum logic [1:0] {
    ST_STD     = 2'h0,
    ST_DET_BB  = 2'h1,
    ST_BB      = 2'h3,
    ST_DET_STD = 2'h2
  } bfc_state_t;
endpackage
`default_nettype wire

// >>> bfc_tick_div.sv
// Purpose: free running divider giving a one-cycle tick
// Assumes: single clock, synchronous active-low reset
// Notes:   tick period is TICK_CYCLES clock cycles
`default_nettype none
module bfc_tick_div #(
  parameter int TICK_CYCLES = bfc_pkg::TICK_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_b,
  output var  logic tick
);
  localparam int CW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("bfc_tick_div: TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } bfc_div_t;

  bfc_div_t s_r;
  bfc_div_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt == LAST) begin
      s_nxt.cnt  = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule
`default_nettype wire

// >>> bfc_failover_control.sv
// Purpose: detach and re-attach the internal function as a billboard device
// Assumes: pins and host events synchronous to clock, APB slave for registers
// Notes:   a failure is taken again only after the notify pin has gone high or the feature was disabled
//
// Register access over APB was left to the implementer.
`default_nettype none
// Function
// (R1) Enable bit turns the failure-notification feature on when one, off when zero.
// (R2) Five-bit field selects notify pin; default code 01010, code 01001 reserved.
// (R3) Selected notify input is active low; low means negotiation failed.
// (R4) External power-delivery controller drives the selected pin low on failure.
// (R5) On failure first force the internal function to detach from its port.
// (R6) Then reconnect it presenting billboard descriptors of class version 1.1.
// (R7) First detach timer starts when the host assigns the device address.
// (R8) Billboard shown only on failure; bmConfigured defaults to unspecified error.
// (R9) Serve the alternate-mode string on request and start the second timer.
// (R10) Second detach timer defaults to twenty seconds.
// (R11) Either timer expiring forces the internal function to detach again.
// (R12) After that detach reconnect with the standard descriptors and function.
// (R13) Each timeout is sixteen bits in low and high bytes, 10 ms units.
// (R14) First timer default is low D0h, high 07h, twenty seconds.
// (R15) Billboard descriptors carry the failure message held in OTP memory.
// (R16) While disabled ignore the pin and keep the standard configuration.
// (R17) Timers advance on a 10 ms tick and clear when standard is restored.
module bfc_failover_control #(
  parameter int NUM_PINS     = 17,
  parameter int TICK_CYCLES  = bfc_pkg::TICK_CYCLES,
  parameter int DETACH_TICKS = bfc_pkg::DETACH_TICKS
) (
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [bfc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  input  wire logic [NUM_PINS-1:0]       notifyPins,
  input  wire logic                      addressSet,
  input  wire logic                      altStringReq,
  output var  logic                      funcConnect,
  output var  logic                      descBillboard,
  output var  logic                      otpStringServe,
  output var  logic [1:0]                bmConfigured,
  output var  logic [15:0]               billboardVersion
);
  localparam int DW = (DETACH_TICKS > 1) ? $clog2(DETACH_TICKS + 1) : 1;
  localparam logic [DW-1:0] DET_LAST = DW'(DETACH_TICKS - 1);

  if (NUM_PINS <= bfc_pkg::DEFAULT_NOTIFY_PIN || NUM_PINS > 32) begin : g_bad_pins
    $error("bfc_failover_control: NUM_PINS must be 11 to 32");
  end
  if (DETACH_TICKS < 1) begin : g_bad_detach
    $error("bfc_failover_control: DETACH_TICKS must be at least 1");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("bfc_failover_control: TICK_CYCLES must be at least 2");
  end
  if (int'(bfc_pkg::CTRL_RST[bfc_pkg::CTRL_SEL_LSB +: bfc_pkg::CTRL_SEL_W])
      != bfc_pkg::DEFAULT_NOTIFY_PIN) begin : g_bad_default
    $error("bfc_failover_control: default pin code and control reset disagree");
  end

  typedef struct packed {
    bfc_pkg::bfc_state_t state;
    logic [7:0]          ctrl;
    logic [7:0]          tmrALo;
    logic [7:0]          tmrAHi;
    logic [7:0]          tmrBLo;
    logic [7:0]          tmrBHi;
    logic [15:0]         cntA;
    logic [15:0]         cntB;
    logic                runA;
    logic                runB;
    logic [DW-1:0]       detCnt;
    logic                armed;
    logic                pinFail;
    logic                funcConnect;
    logic                descBillboard;
    logic                otpStringServe;
    logic [1:0]          bmConfigured;
    logic [15:0]         version;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } bfc_ctl_t;

  bfc_ctl_t s_r;
  bfc_ctl_t s_nxt;
  logic     tick;

  bfc_tick_div #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock (clock),
    .rst_b (rst_b),
    .tick  (tick)
  );

  // byte address to register select
  function automatic bfc_pkg::bfc_regsel_t regSel(input logic [bfc_pkg::ADDR_W-1:0] a);
    logic [15:0] idx;
    idx = 16'(a[bfc_pkg::ADDR_W-1:2]);
    if (a[1:0] != 2'h0) begin
      return bfc_pkg::RS_NONE;
    end
    case (idx)
      bfc_pkg::IDX_TMRA_LO: return bfc_pkg::RS_TMRA_LO;
      bfc_pkg::IDX_TMRA_HI: return bfc_pkg::RS_TMRA_HI;
      bfc_pkg::IDX_TMRB_LO: return bfc_pkg::RS_TMRB_LO;
      bfc_pkg::IDX_TMRB_HI: return bfc_pkg::RS_TMRB_HI;
      bfc_pkg::IDX_CTRL:    return bfc_pkg::RS_CTRL;
      bfc_pkg::IDX_STATUS:  return bfc_pkg::RS_STATUS;
      default:              return bfc_pkg::RS_NONE;
    endcase
  endfunction

  // level of the selected notify pin, one when no valid pin
  function automatic logic pinLevel(input logic [7:0] ctrl, input logic [NUM_PINS-1:0] pins);
    logic [4:0] sel;
    sel = ctrl[bfc_pkg::CTRL_SEL_LSB +: bfc_pkg::CTRL_SEL_W];
    if (sel == bfc_pkg::SEL_RESERVED || int'(sel) >= NUM_PINS) begin
      return 1'b1;
    end
    return pins[sel];
  endfunction

  // (R13) sixteen-bit limit in tick units
  function automatic logic timerExpired(input logic        run,
                                        input logic [15:0] cnt,
                                        input logic [7:0]  hi,
                                        input logic [7:0]  lo);
    return run && (cnt >= {hi, lo});
  endfunction

  // (R17) one count per tick, held at top
  function automatic logic [15:0] timerStep(input logic        t,
                                            input logic        run,
                                            input logic [15:0] cnt);
    if (t && run && cnt != 16'hFFFF) begin
      return cnt + 16'h0001;
    end
    return cnt;
  endfunction

  // refused: unmapped, misaligned or status write
  function automatic logic regRefused(input bfc_pkg::bfc_regsel_t rs, input logic wr);
    return (rs == bfc_pkg::RS_NONE) || (wr && rs == bfc_pkg::RS_STATUS);
  endfunction

  bfc_pkg::bfc_regsel_t sel;
  logic                 enable;
  logic                 detDone;
  logic                 expireA;
  logic                 expireB;
  logic                 answerNow;
  logic                 wrCommit;
  logic [7:0]           statusByte;
  logic [7:0]           readByte;

  always_comb begin
    sel     = regSel(paddr);
    // (R1) feature enable bit
    enable  = s_r.ctrl[bfc_pkg::CTRL_EN_BIT];
    detDone = tick && (s_r.detCnt == DET_LAST);
    // apb answer and write commit points
    answerNow = psel && penable && !s_r.pready;
    wrCommit  = psel && penable && s_r.pready && pwrite && pstrb[0];
    // (R13) sixteen-bit limits in ticks
    expireA = timerExpired(s_r.runA, s_r.cntA, s_r.tmrAHi, s_r.tmrALo);
    expireB = timerExpired(s_r.runB, s_r.cntB, s_r.tmrBHi, s_r.tmrBLo);
    statusByte                       = 8'h00;
    statusByte[1:0]                  = s_r.state;
    statusByte[bfc_pkg::ST_RUNA_BIT] = s_r.runA;
    statusByte[bfc_pkg::ST_RUNB_BIT] = s_r.runB;
    statusByte[bfc_pkg::ST_ARM_BIT]  = s_r.armed;
    statusByte[bfc_pkg::ST_FAIL_BIT] = s_r.pinFail;
    statusByte[bfc_pkg::ST_CONN_BIT] = s_r.funcConnect;
    statusByte[bfc_pkg::ST_BB_BIT]   = s_r.descBillboard;
    case (sel)
      bfc_pkg::RS_TMRA_LO: readByte = s_r.tmrALo;
      bfc_pkg::RS_TMRA_HI: readByte = s_r.tmrAHi;
      bfc_pkg::RS_TMRB_LO: readByte = s_r.tmrBLo;
      bfc_pkg::RS_TMRB_HI: readByte = s_r.tmrBHi;
      bfc_pkg::RS_CTRL:    readByte = s_r.ctrl;
      bfc_pkg::RS_STATUS:  readByte = statusByte;
      default:             readByte = 8'h00;
    endcase
  end

  always_comb begin
    s_nxt                = s_r;
    s_nxt.pready         = 1'b0;
    s_nxt.pslverr        = 1'b0;
    s_nxt.otpStringServe = 1'b0;
    // (R8) unspecified error code in bmConfigured
    s_nxt.bmConfigured   = bfc_pkg::BM_CONFIG_UNSPEC;
    // (R6) class version 1.1
    s_nxt.version        = bfc_pkg::BB_CLASS_VERSION;

    // apb: one wait cycle, then answer
    if (answerNow) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = regRefused(sel, pwrite);
      s_nxt.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, readByte};
    end
    if (wrCommit) begin
      case (sel)
        bfc_pkg::RS_TMRA_LO: s_nxt.tmrALo = pwdata[7:0];
        bfc_pkg::RS_TMRA_HI: s_nxt.tmrAHi = pwdata[7:0];
        bfc_pkg::RS_TMRB_LO: s_nxt.tmrBLo = pwdata[7:0];
        bfc_pkg::RS_TMRB_HI: s_nxt.tmrBHi = pwdata[7:0];
        // (R2) pin select field, reserved bits kept zero
        bfc_pkg::RS_CTRL:    s_nxt.ctrl   = pwdata[7:0] & bfc_pkg::CTRL_MASK;
        default:             s_nxt.ctrl   = s_r.ctrl;
      endcase
    end

    // (R3) active-low notify input
    s_nxt.pinFail = !pinLevel(s_r.ctrl, notifyPins);
    if (!s_r.pinFail || !enable) begin
      s_nxt.armed = 1'b1;
    end

    // (R17) timers advance on the tick
    s_nxt.cntA = timerStep(tick, s_r.runA, s_r.cntA);
    s_nxt.cntB = timerStep(tick, s_r.runB, s_r.cntB);
    if (tick && s_r.state != bfc_pkg::ST_STD && s_r.state != bfc_pkg::ST_BB) begin
      s_nxt.detCnt = s_r.detCnt + DW'(1);
    end

    case (s_r.state)
      bfc_pkg::ST_STD: begin
        s_nxt.funcConnect   = 1'b1;
        s_nxt.descBillboard = 1'b0;
        // (R16) disabled keeps standard
        // (R5) failure forces detach
        if (enable && s_r.pinFail && s_r.armed) begin
          s_nxt.state       = bfc_pkg::ST_DET_BB;
          s_nxt.funcConnect = 1'b0;
          s_nxt.detCnt      = '0;
          s_nxt.armed       = 1'b0;
        end
      end
      bfc_pkg::ST_DET_BB: begin
        if (!enable) begin
          s_nxt.state       = bfc_pkg::ST_STD;
          s_nxt.funcConnect = 1'b1;
        end else if (detDone) begin
          // (R6) reconnect as billboard
          // (R15) descriptors with otp message
          s_nxt.state         = bfc_pkg::ST_BB;
          s_nxt.funcConnect   = 1'b1;
          s_nxt.descBillboard = 1'b1;
          s_nxt.runA          = 1'b0;
          s_nxt.runB          = 1'b0;
        end
      end
      bfc_pkg::ST_BB: begin
        // (R7) address starts first timer
        if (addressSet && !s_r.runA) begin
          s_nxt.runA = 1'b1;
          s_nxt.cntA = 16'h0000;
        end
        // (R9) serve string, start second timer
        if (altStringReq) begin
          s_nxt.otpStringServe = 1'b1;
          if (!s_r.runB) begin
            s_nxt.runB = 1'b1;
            s_nxt.cntB = 16'h0000;
          end
        end
        // (R11) expiry forces detach
        if (expireA || expireB || !enable) begin
          s_nxt.state          = bfc_pkg::ST_DET_STD;
          s_nxt.funcConnect    = 1'b0;
          s_nxt.descBillboard  = 1'b0;
          s_nxt.detCnt         = '0;
          s_nxt.runA           = 1'b0;
          s_nxt.runB           = 1'b0;
        end
      end
      bfc_pkg::ST_DET_STD: begin
        // (R12) reconnect with standard function
        if (detDone) begin
          s_nxt.state       = bfc_pkg::ST_STD;
          s_nxt.funcConnect = 1'b1;
          // (R17) cleared on restore
          s_nxt.cntA        = 16'h0000;
          s_nxt.cntB        = 16'h0000;
        end
      end
      default: begin
        s_nxt.state         = bfc_pkg::ST_STD;
        s_nxt.runA          = 1'b0;
        s_nxt.runB          = 1'b0;
        s_nxt.funcConnect   = 1'b1;
        s_nxt.descBillboard = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_r                <= '0;
      s_r.state          <= bfc_pkg::ST_STD;
      // (R2) default pin code, feature off
      s_r.ctrl           <= bfc_pkg::CTRL_RST;
      // (R14) first timer twenty seconds
      s_r.tmrALo         <= bfc_pkg::TMRA_LO_RST;
      s_r.tmrAHi         <= bfc_pkg::TMRA_HI_RST;
      // (R10) second timer twenty seconds
      s_r.tmrBLo         <= bfc_pkg::TMRB_LO_RST;
      s_r.tmrBHi         <= bfc_pkg::TMRB_HI_RST;
      s_r.armed          <= 1'b1;
      s_r.funcConnect    <= 1'b1;
      s_r.bmConfigured   <= bfc_pkg::BM_CONFIG_UNSPEC;
      s_r.version        <= bfc_pkg::BB_CLASS_VERSION;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata           = s_r.prdata;
  assign pready           = s_r.pready;
  assign pslverr          = s_r.pslverr;
  assign funcConnect      = s_r.funcConnect;
  assign descBillboard    = s_r.descBillboard;
  assign otpStringServe   = s_r.otpStringServe;
  assign bmConfigured     = s_r.bmConfigured;
  assign billboardVersion = s_r.version;
endmodule
`default_nettype wire

// >>> bfc_failover_properties.sv
// Purpose: port checks of the failover control
// Assumes: bench tick of 20 cycles, detach of 2 ticks
// Notes:   bound to every instance of the block
`default_nettype none
module bfc_failover_properties (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        altStringReq,
  input wire logic        funcConnect,
  input wire logic        descBillboard,
  input wire logic        otpStringServe,
  input wire logic [1:0]  bmConfigured,
  input wire logic [15:0] billboardVersion
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_bm_unspec: assert property (bmConfigured == 2'h0)
    else $error("bmConfigured not unspecified");
  a_version_fixed: assert property (billboardVersion == 16'h0110)
    else $error("billboard version wrong");
  a_apb_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_serve_next: assert property (funcConnect && descBillboard && altStringReq
    |=> otpStringServe)
    else $error("string not served");
  a_serve_cause: assert property (otpStringServe |-> $past(altStringReq) && $past(descBillboard))
    else $error("string served without request");
  a_bb_on_attach: assert property ($rose(descBillboard) |-> $rose(funcConnect))
    else $error("billboard without detach");
  a_leave_detach: assert property ($fell(descBillboard) |-> $fell(funcConnect))
    else $error("standard without detach");
  a_detach_hold: assert property ($fell(funcConnect) |=> (!funcConnect)[*8])
    else $error("detach too short");
  a_reattach_bound: assert property ($fell(funcConnect) |-> ##[1:80] funcConnect)
    else $error("no reattach");
endmodule

bind bfc_failover_control bfc_failover_properties u_props (
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .altStringReq(altStringReq),
  .funcConnect(funcConnect), .descBillboard(descBillboard),
  .otpStringServe(otpStringServe), .bmConfigured(bmConfigured),
  .billboardVersion(billboardVersion)
);
`default_nettype wire

// >>> bfc_host_model.sv
// Purpose: host and power-delivery controller stand-in
// Assumes: bench changes requests just after the rising edge
// Notes:   unselected pins idle high
`default_nettype none
module bfc_host_model #(
  parameter int N = 17
) (
  input  wire logic [4:0]   selCode,
  input  wire logic         failNow,
  input  wire logic         addrReq,
  input  wire logic         strReq,
  output var  logic [N-1:0] notifyPins,
  output var  logic         addressSet,
  output var  logic         altStringReq
);
  timeunit 1ns;
  timeprecision 1ps;
  assign notifyPins = ~({{(N-1){1'b0}}, failNow} << selCode);
  assign addressSet = addrReq;
  assign altStringReq = strReq;
endmodule
`default_nettype wire

// >>> bfc_failover_control_tb_top.sv
// Purpose: directed bench of the failover control
// Assumes: short tick and detach parameters
// Notes:   registers reached over APB
`default_nettype none
module bfc_failover_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 20;
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [16:0] notifyPins;
  logic        addressSet, altStringReq, funcConnect, descBillboard, otpStringServe;
  logic [1:0]  bmConfigured;
  logic [15:0] billboardVersion;
  logic [4:0]  selCode;
  logic        failNow, addrReq, strReq;
  logic [7:0]  rstVal [6] = '{8'hD0, 8'h07, 8'hD0, 8'h07, 8'h14, 8'h50};
  int          errorCnt, checkCount, serveCnt, serveBase;

  bfc_failover_control #(.TICK_CYCLES(TICK), .DETACH_TICKS(2)) DUT (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .notifyPins(notifyPins), .addressSet(addressSet),
    .altStringReq(altStringReq), .funcConnect(funcConnect), .descBillboard(descBillboard),
    .otpStringServe(otpStringServe), .bmConfigured(bmConfigured),
    .billboardVersion(billboardVersion));
  bfc_host_model #(.N(17)) host (.selCode(selCode), .failNow(failNow), .addrReq(addrReq),
    .strReq(strReq), .notifyPins(notifyPins), .addressSet(addressSet),
    .altStringReq(altStringReq));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (otpStringServe === 1'b1) serveCnt <= serveCnt + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic waitConn(input logic fc, input logic bb, input int lim);
    int n;
    n = 0;
    while ({funcConnect, descBillboard} !== {fc, bb} && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk("connection", {30'h0, fc, bb}, {30'h0, funcConnect, descBillboard});
  endtask
  task automatic fail(input logic [4:0] code);
    selCode <= code;
    failNow <= 1'b1;
    waitConn(1'b0, 1'b0, 10);
    waitConn(1'b1, 1'b1, 100);
    failNow <= 1'b0;
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    errorCnt++;
    endSim();
  end

  initial begin
    {rst_b, psel, penable, pwrite, failNow, addrReq, strReq} = 7'h0;
    paddr = 18'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    selCode = 5'h0A;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, bfc_pkg::IDX_TMRA_LO + 16'(i), 32'h0);
      chk("reset register", {24'h0, rstVal[i]}, rd);
    end
    chk("idle outputs", {12'h0, 1'b1, 1'b0, 2'h0, 16'h0110},
      {12'h0, funcConnect, descBillboard, bmConfigured, billboardVersion});
    $display("test reset done");
    apb(1'b1, bfc_pkg::IDX_CTRL, 32'hFF);
    apb(1'b0, bfc_pkg::IDX_CTRL, 32'h0);
    chk("control", 32'h3F, rd);
    pstrb <= 4'h0;
    apb(1'b1, bfc_pkg::IDX_CTRL, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, bfc_pkg::IDX_CTRL, 32'h0);
    chk("unstrobed write", 32'h3F, rd);
    apb(1'b0, 16'h4150, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, bfc_pkg::IDX_STATUS, 32'hFF);
    chk("status write error", 32'h1, {31'h0, err});
    apb(1'b1, bfc_pkg::IDX_CTRL, 32'h14);
    failNow <= 1'b1;
    repeat (20) @(posedge clock);
    waitConn(1'b1, 1'b0, 0);
    failNow <= 1'b0;
    $display("test registers done");
    apb(1'b1, bfc_pkg::IDX_TMRA_LO, 32'h05);
    apb(1'b1, bfc_pkg::IDX_TMRA_HI, 32'h00);
    apb(1'b1, bfc_pkg::IDX_CTRL, 32'h15);
    fail(5'h0A);
    addrReq <= 1'b1;
    @(posedge clock);
    addrReq <= 1'b0;
    repeat (60) @(posedge clock);
    waitConn(1'b1, 1'b1, 0);
    waitConn(1'b0, 1'b0, 100);
    waitConn(1'b1, 1'b0, 100);
    $display("test timer a done");
    apb(1'b1, bfc_pkg::IDX_TMRB_LO, 32'h03);
    apb(1'b1, bfc_pkg::IDX_TMRB_HI, 32'h00);
    apb(1'b1, bfc_pkg::IDX_CTRL, 32'h01);
    fail(5'h00);
    serveBase = serveCnt;
    strReq <= 1'b1;
    @(posedge clock);
    strReq <= 1'b0;
    repeat (3) @(posedge clock);
    chk("string served", serveBase + 1, serveCnt);
    waitConn(1'b0, 1'b0, 100);
    waitConn(1'b1, 1'b0, 100);
    $display("test timer b done");
    apb(1'b1, bfc_pkg::IDX_CTRL, 32'h13);
    selCode <= 5'h09;
    failNow <= 1'b1;
    repeat (20) @(posedge clock);
    waitConn(1'b1, 1'b0, 0);
    failNow <= 1'b0;
    $display("test reserved code done");
    endSim();
  end
endmodule
`default_nettype wire
